// [tb/ddc_regs_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module ddc_regs_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        ref_alarm_in,
    input wire logic [15:0] chan_a_out,
    input wire logic [15:0] chan_b_out,
    input wire logic        chan_a_double_gain,
    input wire logic        chan_b_double_gain,
    input wire logic        ref_buffer_enable,
    input wire logic        sync_load_strobe
);
    // completed apb writes and reads
    wire logic wr = psel && penable && pwrite;
    wire logic rd = psel && penable && !pwrite;
    wire logic trg = wr && paddr == 12'h014;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_gain_a; wr && paddr == 12'h010
        |-> ##2 chan_a_double_gain == $past(pwdata[0], 2); endproperty
    a_gain_a: assert property (p_gain_a) else $error("gain a");
    property p_gain_b; wr && paddr == 12'h010
        |-> ##2 chan_b_double_gain == $past(pwdata[1], 2); endproperty
    a_gain_b: assert property (p_gain_b) else $error("gain b");
    property p_load; trg && pwdata[4] && pwdata[3:0] != 4'hA
        |-> ##[1:2] sync_load_strobe; endproperty
    a_load: assert property (p_load) else $error("no load");
    property p_once; sync_load_strobe |=> !sync_load_strobe; endproperty
    a_once: assert property (p_once) else $error("load held");
    property p_trig_rd; rd && paddr == 12'h014 |-> prdata[4:0] == 5'h00;
    endproperty
    a_trig_rd: assert property (p_trig_rd) else $error("trig bits");
    property p_sreset; trg && pwdata[3:0] == 4'hA
        |-> ##2 chan_a_double_gain && chan_b_double_gain; endproperty
    a_sreset: assert property (p_sreset) else $error("sreset");
    property p_alarm; ref_alarm_in [*8] |-> !ref_buffer_enable
        && chan_a_out == 16'h0000 && chan_b_out == 16'h0000; endproperty
    a_alarm: assert property (p_alarm) else $error("alarm out");
    property p_status; $stable(ref_alarm_in) [*6] ##0 (rd && paddr == 12'h01C)
        |-> prdata[0] == ref_alarm_in; endproperty
    a_status: assert property (p_status) else $error("status");
endmodule // ddc_regs_checker
bind ddc_regs ddc_regs_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .ref_alarm_in, .chan_a_out,
    .chan_b_out, .chan_a_double_gain, .chan_b_double_gain,
    .ref_buffer_enable, .sync_load_strobe);
`default_nettype wire

// [tb/ddc_regs_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module ddc_regs_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        reset_level_select = 1'b1;
    logic        ref_alarm_in = 1'b0;
    logic [31:0] rd;
    logic        serr;
    int          err_count = 0;
    int          check_count = 0;
    int          strobes = 0;
    int          i;
    wire logic        pready, pslverr, irq, ref_buffer_enable;
    wire logic        chan_a_double_gain, chan_b_double_gain, sync_load_strobe;
    wire logic [31:0] prdata;
    wire logic [15:0] chan_a_out, chan_b_out;
    always #10 pclk = ~pclk;
    // count load pulses
    always @(posedge pclk) strobes <= strobes + int'(sync_load_strobe);
    ddc_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .pslverr, .prdata, .reset_level_select, .ref_alarm_in,
        .chan_a_out, .chan_b_out, .chan_a_double_gain, .chan_b_double_gain,
        .ref_buffer_enable, .sync_load_strobe, .irq);
    // one apb transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        serr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task t_reset;
        rdc(12'h010, 32'h0000_0003);
        rdc(12'h01C, 32'h0000_0000);
        rdc(12'h024, 32'h0000_8000);
        chk({16'h0000, chan_a_out}, 32'h0000_8000);
        apb(1'b1, 12'h014, 32'h0000_ffe0);
        rdc(12'h014, 32'h0000_ffe0);
        rdc(12'h040, 32'h0000_0000);
        chk({31'h0000_0000, serr}, 32'h0000_0001);
        $display("test reset done");
    endtask
    task t_gain;
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h010, 32'(i));
            repeat (4) @(posedge pclk);
            chk({30'h0000_0000, chan_b_double_gain, chan_a_double_gain},
                32'(i));
        end
        $display("test gain done");
    endtask
    task t_sync;
        apb(1'b1, 12'h028, 32'h0000_0201);
        apb(1'b1, 12'h020, 32'h0000_1234);
        apb(1'b1, 12'h018, 32'h0000_abcd);
        repeat (4) @(posedge pclk);
        chk({chan_a_out, chan_b_out}, 32'h8000_abcd);
        i = strobes;
        apb(1'b1, 12'h014, 32'h0000_0010);
        repeat (4) @(posedge pclk);
        chk({chan_a_out, 16'(strobes - i)}, 32'h1234_0001);
        rdc(12'h020, 32'h0000_1234);
        $display("test sync done");
    endtask
    task t_alarm;
        apb(1'b1, 12'h030, 32'h0000_0001);
        ref_alarm_in <= 1'b1;
        repeat (10) @(posedge pclk);
        chk({ref_buffer_enable, irq, chan_a_out, chan_b_out[13:0]},
            32'h4000_0000);
        apb(1'b1, 12'h01C, 32'h0000_0000);
        rdc(12'h01C, 32'h0000_0001);
        ref_alarm_in <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({ref_buffer_enable, irq, chan_a_out, chan_b_out[13:0]},
            32'hc48d_2bcd);
        apb(1'b1, 12'h02C, 32'h0000_000f);
        @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        $display("test alarm done");
    endtask
    task t_sreset;
        apb(1'b1, 12'h010, 32'h0000_0000);
        apb(1'b1, 12'h014, 32'h0000_0005);
        repeat (4) @(posedge pclk);
        chk({chan_a_out, 14'h0000, chan_b_double_gain, chan_a_double_gain},
            32'h1234_0000);
        apb(1'b1, 12'h014, 32'h0000_000a);
        repeat (4) @(posedge pclk);
        chk({chan_a_out, 14'h0000, chan_b_double_gain, chan_a_double_gain},
            32'h8000_0003);
        // level pin low: soft reset now gives zero codes
        reset_level_select <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b1, 12'h014, 32'h0000_000a);
        repeat (4) @(posedge pclk);
        chk({16'h0000, chan_a_out}, 32'h0000_0000);
        rdc(12'h024, 32'h0000_0000);
        $display("test soft reset done");
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence and watchdog
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        t_reset;
        t_gain;
        t_sync;
        t_alarm;
        t_sreset;
        end_of_test;
    end
    initial
    begin
        #100000;
        err_count++;
        end_of_test;
    end
endmodule // ddc_regs_tb_top
`default_nettype wire

// [verilog/ddc_defs.vh]
`ifndef DDC_DEFS_VH
`define DDC_DEFS_VH
// register indices (printed offsets), byte address is index times four
`define DDC_IDX_GAIN      4'h4
`define DDC_IDX_TRIGGER   4'h5
`define DDC_IDX_BCAST     4'h6
`define DDC_IDX_STATUS    4'h7
`define DDC_IDX_CHAN_A    4'h8
`define DDC_IDX_CHAN_B    4'h9
`define DDC_IDX_SYNC      4'hA
`define DDC_IDX_IRQ_STAT  4'hB
`define DDC_IDX_IRQ_MASK  4'hC
// field positions
`define DDC_GAIN_A_BIT    0
`define DDC_GAIN_B_BIT    1
`define DDC_TRIG_LOAD_BIT 4
`define DDC_SYNC_A_BIT    0
`define DDC_SYNC_B_BIT    1
`define DDC_BCAST_A_BIT   8
`define DDC_BCAST_B_BIT   9
`define DDC_ALARM_BIT     0
// interrupt status bits
`define DDC_IRQ_ALARM_SET 0
`define DDC_IRQ_ALARM_CLR 1
`define DDC_IRQ_LOAD      2
`define DDC_IRQ_SRESET    3
// values
`define DDC_SRESET_CODE   4'hA
`define DDC_GAIN_RESET    16'h0003
`define DDC_SYNC_RESET    16'h0000
`define DDC_CODE_ZERO     16'h0000
`define DDC_CODE_MID      16'h8000
// timing: edges until the level pin synchroniser is filled
`define DDC_SETTLE_CYCLES 2'b11
`endif

// [verilog/ddc_regs.v]
// Functional notes
// - channel b gain bit set gives channel b a gain of two
// - channel a gain bit, bit 0, set gives channel a gain of two
// - cleared gain bit gives that channel unity gain
// - trigger bit 4 loads all synchronous channels, then self-clears
// - code 1010 in trigger bits 3-0 resets the device, field self-clears
// - broadcast write updates active data of broadcast-enabled channels only
// - broadcast data msb aligned; narrow variants ignore low bits
// - broadcast register resets to 0000h or 8000h per level select pin
// - status bit 0 mirrors reference alarm, read only
// - alarm forces outputs to zero, stored codes kept, resumes after
// - channel data registers read/write, reset per level select pin
// - trigger bits 15-5 are plain storage, reset zero
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ddc_defs.vh"
module ddc_regs
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        reset_level_select,
    input  wire        ref_alarm_in,
    output reg  [15:0] chan_a_out,
    output reg  [15:0] chan_b_out,
    output reg         chan_a_double_gain,
    output reg         chan_b_double_gain,
    output reg         ref_buffer_enable,
    output reg         sync_load_strobe,
    output wire        irq
);

    // register map, byte address is four times the index
    // 0x10 gain select: bit 0 channel a, bit 1 channel b
    //      one means gain of two, zero means unity gain
    //      upper bits kept as plain storage
    // 0x14 trigger: bits 3:0 soft-reset field, bit 4 load strobe
    //      bits 15:5 plain storage, low five bits read as zero
    //      reset code and load both written: codes take reset, load strobe still pulses
    // 0x18 broadcast value: write only, reads as zero
    //      copied into active code of broadcast channels
    // 0x1c status: bit 0 live reference alarm, read only
    //      bits 15:1 plain storage
    // 0x20 channel a code, 0x24 channel b code
    //      staged here; applied at once unless synchronous
    // 0x28 channel mode: bits 1:0 synchronous per channel
    //      bits 9:8 broadcast enable per channel
    // 0x2c interrupt status, write one to clear
    //      bit 0 alarm rise, bit 1 alarm fall
    //      bit 2 load strobe, bit 3 soft reset
    //      a new event in the clearing cycle is kept
    // 0x30 interrupt mask, same layout as status
    // any other address answers with an error response
    //
    // start-up: codes follow the level pin once synchronised,
    //      so the pin must not be sampled before its flops fill
    // soft reset keeps interrupt status, clears the mask
    // alarm gives zero outputs, stored codes survive

    // staged registers and status
    reg  [15:0] gain_reg;
    reg  [10:0] trig_hi;
    reg  [15:0] all_channel_write_value;
    reg  [14:0] status_hi;
    wire [15:0] code_a;
    wire [15:0] code_b;
    wire [15:0] active_a;
    wire [15:0] active_b;
    wire [15:0] chan_code [0:1];
    wire [15:0] chan_active [0:1];
    reg  [1:0]  settle;
    wire        boot_load;
    wire [15:0] boot_code;
    genvar      gc;
    reg  [15:0] sync_cfg;
    reg  [3:0]  irq_stat;
    reg  [3:0]  irq_mask;
    reg  [2:0]  lvl_sync;
    reg  [2:0]  alm_sync;
    reg         level;
    reg         alarm;
    reg         alarm_q;
    reg         rst_done;
    wire        wr;
    wire        rd_unmapped;
    wire [3:0]  idx;
    wire [15:0] wd;
    wire        soft_rst;
    wire        load_req;
    wire [15:0] reset_code;
    reg  [3:0]  next_irq_set;

    assign pready  = 1'b1;
    assign idx     = paddr[5:2];
    assign wd      = pwdata[15:0];
    assign wr      = psel & penable & pwrite;
    assign rd_unmapped = (paddr[11:6] != 6'h00) || (paddr[1:0] != 2'b00)
                      || (idx < `DDC_IDX_GAIN) || (idx > `DDC_IDX_IRQ_MASK);
    assign pslverr = psel & penable & rd_unmapped;
    assign soft_rst = wr & ~rd_unmapped & (idx == `DDC_IDX_TRIGGER)
                    & (wd[3:0] == `DDC_SRESET_CODE);
    assign load_req = wr & ~rd_unmapped & (idx == `DDC_IDX_TRIGGER)
                    & wd[`DDC_TRIG_LOAD_BIT];
    assign reset_code = level ? `DDC_CODE_MID : `DDC_CODE_ZERO;
    assign irq = |(irq_stat & irq_mask);

    // start-up capture of the level pin once the synchroniser is filled
    assign boot_load = ~rst_done & (settle == `DDC_SETTLE_CYCLES)
                     & (lvl_sync[1] == lvl_sync[2]);
    assign boot_code = lvl_sync[2] ? `DDC_CODE_MID : `DDC_CODE_ZERO;

    // pin synchronisers, change counts when stages two and three agree
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl_sync <= 3'b000;
            alm_sync <= 3'b000;
            level    <= 1'b0;
            alarm    <= 1'b0;
        end
        else
        begin
            lvl_sync <= {lvl_sync[1:0], reset_level_select};
            alm_sync <= {alm_sync[1:0], ref_alarm_in};
            if (lvl_sync[1] == lvl_sync[2])
                level <= lvl_sync[2];
            if (alm_sync[1] == alm_sync[2])
                alarm <= alm_sync[2];
        end
    end

    // interrupt events
    always @*
    begin
        next_irq_set = 4'h0;
        next_irq_set[`DDC_IRQ_ALARM_SET] = alarm & ~alarm_q;
        next_irq_set[`DDC_IRQ_ALARM_CLR] = ~alarm & alarm_q;
        next_irq_set[`DDC_IRQ_LOAD]      = load_req;
        next_irq_set[`DDC_IRQ_SRESET]    = soft_rst;
    end

    // register file, interrupts, start-up and soft reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_reg   <= `DDC_GAIN_RESET;
            trig_hi    <= 11'h000;
            status_hi  <= 15'h0000;
            sync_cfg   <= `DDC_SYNC_RESET;
            all_channel_write_value <= `DDC_CODE_ZERO;
            settle     <= 2'b00;
            irq_stat   <= 4'h0;
            irq_mask   <= 4'h0;
            alarm_q    <= 1'b0;
            rst_done   <= 1'b0;
            sync_load_strobe <= 1'b0;
        end
        else
        begin
            alarm_q <= alarm;
            sync_load_strobe <= load_req;
            // set wins over a write-one clear
            if (wr & ~rd_unmapped & (idx == `DDC_IDX_IRQ_STAT))
                irq_stat <= (irq_stat & ~wd[3:0]) | next_irq_set;
            else
                irq_stat <= irq_stat | next_irq_set;
            // settle count for the level pin synchroniser
            if (settle != `DDC_SETTLE_CYCLES)
                settle <= settle + 2'b01;
            // catch level select after release, once synchronised
            if (boot_load)
            begin
                rst_done <= 1'b1;
                all_channel_write_value <= boot_code;
            end
            else if (soft_rst)
            begin
                gain_reg  <= `DDC_GAIN_RESET;
                trig_hi   <= 11'h000;
                status_hi <= 15'h0000;
                sync_cfg  <= `DDC_SYNC_RESET;
                all_channel_write_value <= reset_code;
                irq_mask  <= 4'h0;
            end
            else if (wr & ~rd_unmapped)
            begin
                case (idx)
                    `DDC_IDX_GAIN:    gain_reg <= wd;
                    `DDC_IDX_TRIGGER: trig_hi <= wd[15:5];
                    `DDC_IDX_BCAST:   all_channel_write_value <= wd;
                    `DDC_IDX_STATUS:  status_hi <= wd[15:1];
                    `DDC_IDX_SYNC:     sync_cfg <= wd;
                    `DDC_IDX_IRQ_MASK: irq_mask <= wd[3:0];
                    default:           sync_cfg <= sync_cfg;
                endcase
            end
        end
    end

    // per channel staged code and active code
    generate
        for (gc = 0; gc < 2; gc = gc + 1)
        begin : g_chan
            reg  [15:0] code;
            reg  [15:0] active;
            wire [3:0]  ch_idx;
            wire        ch_sync;
            wire        ch_bcast;
            wire        ch_wr;

            // channel decode and mode bits
            assign ch_idx   = (gc == 0) ? `DDC_IDX_CHAN_A : `DDC_IDX_CHAN_B;
            assign ch_sync  = sync_cfg[`DDC_SYNC_A_BIT + gc];
            assign ch_bcast = sync_cfg[`DDC_BCAST_A_BIT + gc];
            assign ch_wr    = wr & ~rd_unmapped;

            // start-up and soft reset win over any bus write
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    code   <= `DDC_CODE_ZERO;
                    active <= `DDC_CODE_ZERO;
                end
                else if (boot_load)
                begin
                    code   <= boot_code;
                    active <= boot_code;
                end
                else if (soft_rst)
                begin
                    code   <= reset_code;
                    active <= reset_code;
                end
                else if (ch_wr && idx == ch_idx)
                begin
                    code <= wd;
                    if (!ch_sync)
                        active <= wd;
                end
                else if (ch_wr && idx == `DDC_IDX_BCAST && ch_bcast)
                    active <= wd;
                else if (load_req && ch_sync)
                    active <= code;
            end

            // hand codes out of the loop
            assign chan_code[gc]   = code;
            assign chan_active[gc] = active;
        end
    endgenerate

    // named views of the channel codes
    assign code_a   = chan_code[0];
    assign code_b   = chan_code[1];
    assign active_a = chan_active[0];
    assign active_b = chan_active[1];

    // analog-facing outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_a_out         <= `DDC_CODE_ZERO;
            chan_b_out         <= `DDC_CODE_ZERO;
            chan_a_double_gain <= 1'b1;
            chan_b_double_gain <= 1'b1;
            ref_buffer_enable  <= 1'b0;
        end
        else
        begin
            chan_a_double_gain <= gain_reg[`DDC_GAIN_A_BIT];
            chan_b_double_gain <= gain_reg[`DDC_GAIN_B_BIT];
            ref_buffer_enable  <= ~alarm;
            chan_a_out <= alarm ? `DDC_CODE_ZERO : active_a;
            chan_b_out <= alarm ? `DDC_CODE_ZERO : active_b;
        end
    end

    // read mux; trigger strobes and broadcast read as zero
    always @*
    begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && !rd_unmapped)
        begin
            case (idx)
                `DDC_IDX_GAIN:     prdata[15:0] = gain_reg;
                `DDC_IDX_TRIGGER:  prdata[15:0] = {trig_hi, 5'h00};
                `DDC_IDX_STATUS:   prdata[15:0] = {status_hi, alarm};
                `DDC_IDX_CHAN_A:   prdata[15:0] = code_a;
                `DDC_IDX_CHAN_B:   prdata[15:0] = code_b;
                `DDC_IDX_SYNC:     prdata[15:0] = sync_cfg;
                `DDC_IDX_IRQ_STAT: prdata[3:0]  = irq_stat;
                `DDC_IDX_IRQ_MASK: prdata[3:0]  = irq_mask;
                default:           prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // ddc_regs
`default_nettype wire
